// ### design/sphold_pkg.sv
// Constants and types shared by the standby pin-state hold block
package sphold_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_PINS_DEF = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAKE_LIGHT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WAKE_DEEP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PAD_IN = 8'h10;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_STATE_W = 3;
  localparam int STAT_WOKE_BIT = 8;
  localparam logic CTRL_HOLD_RST = 1'b0;
  localparam logic WOKE_RST = 1'b0;
  localparam logic [DATA_W-1:0] WAKE_MASK_RST = 32'h0000_0000;

  // ==========================================================
  // Timing
  localparam int STARTUP_CYCLES = 8;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    REQ_RUN,
    REQ_LIGHT,
    REQ_DEEP
  } sphold_req_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_LIGHT,
    ST_DEEP,
    ST_HOLD,
    ST_STARTUP
  } sphold_state_t;

  // Per-pin request from the port logic
  typedef struct packed {
    logic drive;
    logic dir_out;
    logic in_en;
    logic pull;
    logic spec;
  } sphold_core_t;

  // Per-pin control towards the pad
  typedef struct packed {
    logic out;
    logic oe_n;
    logic ie;
    logic pu;
  } sphold_pad_t;

endpackage

// ### design/sphold_pin_cell.sv
// One pad's state keeper for the standby pin-state hold block
`timescale 1ns/100ps
`default_nettype none
module sphold_pin_cell
  import sphold_pkg::*;
#(
  parameter bit IS_TDO = 1'b0,
  parameter bit IS_PU = 1'b0,
  parameter bit IS_IRQ = 1'b0,
  parameter bit IS_DEEP_WAKE = 1'b0,
  parameter bit IS_USB = 1'b0,
  parameter bit IS_ANALOG = 1'b0,
  parameter bit IS_TOGGLE = 1'b0
)
(
  input wire logic clock,
  input wire logic srst,
  input wire sphold_state_t state,
  input wire sphold_core_t core,
  input wire logic wake_light_en,
  input wire logic wake_deep_en,
  output sphold_pad_t pad
);

  // ==========================================================
  // Decode
  sphold_core_t snap_reg;
  sphold_core_t snap_next;
  sphold_pad_t pad_reg;
  sphold_pad_t pad_next;
  sphold_core_t src;
  wire logic is_run = state == ST_RUN;
  wire logic is_light = state == ST_LIGHT;
  wire logic is_start = state == ST_STARTUP;
  wire logic is_kept = state == ST_DEEP || state == ST_HOLD;
  wire logic live = is_light && core.spec && (IS_ANALOG || IS_TOGGLE);
  wire logic light_ie = (IS_IRQ && wake_light_en)
    || (IS_USB && !snap_reg.dir_out);
  wire logic deep_ie = IS_DEEP_WAKE && wake_deep_en;

  // ==========================================================
  // Selection
  assign snap_next = is_run ? core : snap_reg;
  assign src = (is_run || live) ? core : snap_reg;
  assign pad_next.out = is_start ? (IS_TDO && core.drive) : src.drive;
  assign pad_next.oe_n = is_start ? !IS_TDO : !src.dir_out;
  assign pad_next.ie = is_run ? core.in_en :
    is_light ? light_ie :
    is_kept ? deep_ie : 1'b0;
  assign pad_next.pu = is_start ? 1'b0 : src.pull;

  // ==========================================================
  // Flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      snap_reg <= '0;
      pad_reg <= '{out: 1'b0, oe_n: !IS_TDO, ie: 1'b0, pu: IS_PU};
    end
    else
    begin
      snap_reg <= snap_next;
      pad_reg <= pad_next;
    end
  end

  assign pad = pad_reg;

endmodule // sphold_pin_cell
`default_nettype wire

// ### design/sphold_regs.sv
// Software registers of the standby pin-state hold block
`timescale 1ns/100ps
`default_nettype none
module sphold_regs
  import sphold_pkg::*;
#(
  parameter int NUM_PINS = NUM_PINS_DEF
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire sphold_state_t state,
  input wire logic woke_set,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic io_state_hold,
  output logic [NUM_PINS-1:0] wake_light_en,
  output logic [NUM_PINS-1:0] wake_deep_en,
  output logic [DATA_W-1:0] bus_rdata
);

  // ==========================================================
  // Decode
  logic hold_reg;
  logic hold_next;
  logic woke_reg;
  logic woke_next;
  logic [NUM_PINS-1:0] wl_reg;
  logic [NUM_PINS-1:0] wl_next;
  logic [NUM_PINS-1:0] wd_reg;
  logic [NUM_PINS-1:0] wd_next;
  logic [DATA_W-1:0] rd_reg;
  logic [DATA_W-1:0] rd_next;
  logic [DATA_W-1:0] stat_word;
  wire logic sel_ctrl = bus_addr == OFS_CTRL;
  wire logic sel_wl = bus_addr == OFS_WAKE_LIGHT;
  wire logic sel_wd = bus_addr == OFS_WAKE_DEEP;
  wire logic sel_stat = bus_addr == OFS_STATUS;
  wire logic sel_pin = bus_addr == OFS_PAD_IN;
  wire logic woke_clr = bus_wr && sel_stat && bus_wdata[STAT_WOKE_BIT];

  // ==========================================================
  // Next values
  assign hold_next = (bus_wr && sel_ctrl) ? bus_wdata[CTRL_HOLD_BIT] : hold_reg;
  assign wl_next = (bus_wr && sel_wl) ? bus_wdata[NUM_PINS-1:0] : wl_reg;
  assign wd_next = (bus_wr && sel_wd) ? bus_wdata[NUM_PINS-1:0] : wd_reg;
  assign woke_next = woke_set || (woke_reg && !woke_clr);
  assign stat_word = {{(DATA_W-STAT_WOKE_BIT-1){1'b0}}, woke_reg,
    {(STAT_WOKE_BIT-STAT_STATE_W){1'b0}}, state};
  assign rd_next = !bus_rd ? '0 :
    sel_ctrl ? DATA_W'(hold_reg) :
    sel_wl ? DATA_W'(wl_reg) :
    sel_wd ? DATA_W'(wd_reg) :
    sel_stat ? stat_word :
    sel_pin ? DATA_W'(pad_in) : '0;

  // ==========================================================
  // Flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hold_reg <= CTRL_HOLD_RST;
      woke_reg <= WOKE_RST;
      wl_reg <= WAKE_MASK_RST[NUM_PINS-1:0];
      wd_reg <= WAKE_MASK_RST[NUM_PINS-1:0];
      rd_reg <= '0;
    end
    else
    begin
      hold_reg <= hold_next;
      woke_reg <= woke_next;
      wl_reg <= wl_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
    end
  end

  assign io_state_hold = hold_reg;
  assign wake_light_en = wl_reg;
  assign wake_deep_en = wd_reg;
  assign bus_rdata = rd_reg;

endmodule // sphold_regs
`default_nettype wire

// ### design/sphold_top.sv
// Pin-state control across light and deep standby
// How it works
// - Entering light standby, output pins keep driving their previous level, except enabled analog and toggle outputs.
// - In light standby, input pins go high-impedance with input buffers off.
// - In deep standby, every pin keeps direction and driven level unchanged.
// - Leaving deep standby with hold clear, pins float; test output keeps driving.
// - Leaving deep standby with hold set, pins stay kept until software clears it.
// - Light-standby wake interrupt pins keep their input buffer enabled.
// - Deep-standby wake pins keep their input buffer enabled.
// - In light standby, USB data pins used as inputs keep input enabled.
// - In light standby, enabled analog output keeps presenting its value.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sphold_top
  import sphold_pkg::*;
#(
  parameter int NUM_PINS = NUM_PINS_DEF,
  parameter int STARTUP_LEN = STARTUP_CYCLES,
  parameter logic [NUM_PINS-1:0] TDO_MASK = '0,
  parameter logic [NUM_PINS-1:0] PU_MASK = '0,
  parameter logic [NUM_PINS-1:0] IRQ_MASK = '0,
  parameter logic [NUM_PINS-1:0] DEEP_MASK = '0,
  parameter logic [NUM_PINS-1:0] USB_MASK = '0,
  parameter logic [NUM_PINS-1:0] ANALOG_MASK = '0,
  parameter logic [NUM_PINS-1:0] TOGGLE_MASK = '0
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DATA_W-1:0] bus_rdata,
  input wire sphold_req_t mode_req,
  input wire sphold_core_t [NUM_PINS-1:0] core_ctl,
  input wire logic [NUM_PINS-1:0] pad_in,
  output sphold_pad_t [NUM_PINS-1:0] pad_ctl,
  output sphold_state_t power_state
);

  localparam int CNT_W = $clog2(STARTUP_LEN) + 1;

  // ==========================================================
  // Signals
  sphold_state_t state_reg;
  sphold_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic io_state_hold;
  logic [NUM_PINS-1:0] wake_light_en;
  logic [NUM_PINS-1:0] wake_deep_en;
  wire logic light_wake = |(pad_in & wake_light_en & IRQ_MASK);
  wire logic deep_wake = |(pad_in & wake_deep_en & DEEP_MASK);
  wire logic cnt_done = cnt_reg == CNT_W'(STARTUP_LEN - 1);
  wire logic woke_set = (state_reg == ST_LIGHT && light_wake)
    || (state_reg == ST_DEEP && deep_wake);

  // ==========================================================
  // Registers
  sphold_regs #(
    .NUM_PINS(NUM_PINS)
  ) u_regs (
    .clock(clock),
    .srst(srst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .state(state_reg),
    .woke_set(woke_set),
    .pad_in(pad_in),
    .io_state_hold(io_state_hold),
    .wake_light_en(wake_light_en),
    .wake_deep_en(wake_deep_en),
    .bus_rdata(bus_rdata)
  );

  // ==========================================================
  // Mode sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (mode_req == REQ_LIGHT)
          state_next = ST_LIGHT;
        else if (mode_req == REQ_DEEP)
          state_next = ST_DEEP;
      end
      ST_LIGHT:
      begin
        if (light_wake || mode_req == REQ_RUN)
          state_next = ST_RUN;
      end
      ST_DEEP:
      begin
        if (deep_wake || mode_req == REQ_RUN)
          state_next = io_state_hold ? ST_HOLD : ST_STARTUP;
      end
      ST_HOLD:
      begin
        if (!io_state_hold)
          state_next = ST_RUN;
      end
      ST_STARTUP:
      begin
        if (cnt_done)
          state_next = ST_RUN;
      end
      default:
        state_next = ST_RUN;
    endcase
  end

  assign cnt_next = (state_reg == ST_STARTUP && !cnt_done) ?
    cnt_reg + CNT_W'(1) : '0;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= ST_RUN;
      cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign power_state = state_reg;

  // ==========================================================
  // Pad cells
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++)
    begin : g_pin
      sphold_pin_cell #(
        .IS_TDO(TDO_MASK[i]),
        .IS_PU(PU_MASK[i]),
        .IS_IRQ(IRQ_MASK[i]),
        .IS_DEEP_WAKE(DEEP_MASK[i]),
        .IS_USB(USB_MASK[i]),
        .IS_ANALOG(ANALOG_MASK[i]),
        .IS_TOGGLE(TOGGLE_MASK[i])
      ) u_cell (
        .clock(clock),
        .srst(srst),
        .state(state_reg),
        .core(core_ctl[i]),
        .wake_light_en(wake_light_en[i]),
        .wake_deep_en(wake_deep_en[i]),
        .pad(pad_ctl[i])
      );
    end
  endgenerate

endmodule // sphold_top
`default_nettype wire

// ### bench/sphold_checker.sv
// Assertions for the standby pin-state hold block
`timescale 1ns/100ps
`default_nettype none
module sphold_checker
  import sphold_pkg::*;
#(
  parameter int NUM_PINS = NUM_PINS_DEF
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire sphold_core_t [NUM_PINS-1:0] core_ctl,
  input wire sphold_pad_t [NUM_PINS-1:0] pad_ctl,
  input wire sphold_state_t power_state
);
  // ====
  // Mode decode
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire logic lit = power_state == ST_LIGHT;
  wire logic kp = power_state inside {ST_DEEP, ST_HOLD};
  // ====
  // Properties
  a_light_keep: assert property (lit && $past(lit) |->
    $stable({pad_ctl[4].out, pad_ctl[4].oe_n})) else $error("light drift");
  a_light_float: assert property ($past(lit) |->
    !pad_ctl[6].ie && !pad_ctl[4].ie) else $error("light input on");
  a_deep_keep: assert property (kp && $past(kp) |->
    $stable({pad_ctl[4].out, pad_ctl[4].oe_n})) else $error("deep drift");
  a_startup_pads: assert property ($past(power_state) == ST_STARTUP |->
    pad_ctl[6].oe_n && !pad_ctl[6].ie && !pad_ctl[0].oe_n)
    else $error("startup pads");
  a_hold_stays: assert property ((power_state == ST_HOLD && !bus_wr) [*3]
    |=> power_state == ST_HOLD) else $error("hold left");
  a_usb_input: assert property ($past(lit) |->
    pad_ctl[2].ie == pad_ctl[2].oe_n) else $error("usb input");
  a_analog_live: assert property ($past(lit && core_ctl[3].spec) |->
    pad_ctl[3].out == $past(core_ctl[3].drive)) else $error("analog out");
  a_toggle_live: assert property ($past(lit && core_ctl[5].spec) |->
    pad_ctl[5].out == $past(core_ctl[5].drive)) else $error("toggle out");
  a_reset_pads: assert property (disable iff (1'h0) srst |=>
    !pad_ctl[0].oe_n && pad_ctl[1].pu && pad_ctl[6].oe_n)
    else $error("reset pads");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == '0)
    else $error("read data idle");
  c_light_exit: cover property (lit ##1 !lit);
  c_hold: cover property (power_state == ST_HOLD);
  c_startup: cover property (power_state == ST_STARTUP);
endmodule // sphold_checker
bind sphold_top sphold_checker #(.NUM_PINS(NUM_PINS)) i_chk (
  .clock(clock), .srst(srst), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .core_ctl(core_ctl), .pad_ctl(pad_ctl),
  .power_state(power_state));
`default_nettype wire

// ### bench/sphold_top_tb.sv
// Self-checking bench for the standby pin-state hold block
`timescale 1ns/100ps
`default_nettype none
module sphold_top_tb
  import sphold_pkg::*;
;
  // ====
  // Signals
  localparam int NP = 7;
  // Pin classes, one bit per pin
  localparam logic [NP-1:0] TDO_M = 7'h01;
  localparam logic [NP-1:0] PU_M = 7'h02;
  localparam logic [NP-1:0] IRQ_M = 7'h02;
  localparam logic [NP-1:0] DEEP_M = 7'h04;
  localparam logic [NP-1:0] USB_M = 7'h04;
  localparam logic [NP-1:0] ANA_M = 7'h08;
  localparam logic [NP-1:0] TOG_M = 7'h20;
  typedef struct {
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] e;
  } sphold_row_t;
  logic clock;
  logic srst = 1'h1;
  logic [ADDR_W-1:0] bus_addr = '0;
  logic [DATA_W-1:0] bus_wdata = '0;
  logic bus_wr = 1'h0;
  logic bus_rd = 1'h0;
  logic [DATA_W-1:0] bus_rdata;
  logic [DATA_W-1:0] rv;
  sphold_req_t mode_req = REQ_RUN;
  sphold_core_t [NP-1:0] core_ctl =
    {5'h04, 5'h19, 5'h18, 5'h19, 5'h04, 5'h06, 5'h10};
  logic [NP-1:0] pad_in = '0;
  sphold_pad_t [NP-1:0] pad_ctl;
  sphold_state_t power_state;
  int errors = 0;
  int checks = 0;
  sphold_row_t rows [5] = '{'{OFS_CTRL, 32'hffff_fffe, 32'h0},
    '{OFS_WAKE_LIGHT, 32'hffff_ffff, 32'h7f},
    '{OFS_WAKE_DEEP, 32'h0000_00a4, 32'h24},
    '{OFS_PAD_IN, 32'hffff_ffff, 32'h0},
    '{8'h14, 32'hffff_ffff, 32'h0}};
  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  sphold_top #(.NUM_PINS(NP), .TDO_MASK(TDO_M), .PU_MASK(PU_M),
    .IRQ_MASK(IRQ_M), .DEEP_MASK(DEEP_M), .USB_MASK(USB_M),
    .ANALOG_MASK(ANA_M), .TOGGLE_MASK(TOG_M)) i_dut (
    .clock(clock), .srst(srst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .mode_req(mode_req), .core_ctl(core_ctl),
    .pad_in(pad_in), .pad_ctl(pad_ctl), .power_state(power_state));
  // ====
  // Tasks
  task automatic chk(input string n, input logic [DATA_W-1:0] s, e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge clock);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clock);
    bus_rd <= 1'h0;
    #1 rv = bus_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wst(input sphold_state_t s);
    int i;
    i = 0;
    while (power_state !== s && i < 40)
    begin
      cyc(1);
      i++;
    end
    chk("state", power_state, s);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ====
  // Watchdog
  initial
  begin
    #20000;
    errors++;
    report_and_stop();
  end
  // ====
  // Tests
  initial
  begin
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    #1;
    chk("rst_pads", {pad_ctl[0].oe_n, pad_ctl[1].pu, pad_ctl[6].oe_n}, 3);
    $display("test reset done");
    foreach (rows[k])
    begin
      rd(rows[k].a);
      chk("reg_rst", rv, 32'h0);
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a);
      chk("reg_rw", rv, rows[k].e);
    end
    $display("test regs done");
    @(posedge clock);
    mode_req <= REQ_LIGHT;
    wst(ST_LIGHT);
    @(posedge clock);
    core_ctl[4] <= 5'h08;
    core_ctl[3] <= 5'h09;
    core_ctl[5] <= 5'h09;
    cyc(3);
    chk("keep_out", pad_ctl[4].out, 1);
    chk("in_float", {pad_ctl[6].oe_n, pad_ctl[6].ie}, 2);
    chk("irq_ie", pad_ctl[1].ie, 1);
    chk("usb_ie", pad_ctl[2].ie, 1);
    chk("live_out", {pad_ctl[3].out, pad_ctl[5].out}, 0);
    @(posedge clock);
    pad_in[1] <= 1'h1;
    wst(ST_RUN);
    @(posedge clock);
    pad_in[1] <= 1'h0;
    mode_req <= REQ_RUN;
    cyc(3);
    rd(OFS_STATUS);
    chk("woke", rv, 32'h100);
    wr(OFS_STATUS, 32'h100);
    $display("test light done");
    wr(OFS_CTRL, 32'h1);
    mode_req <= REQ_DEEP;
    wst(ST_DEEP);
    @(posedge clock);
    core_ctl[4] <= 5'h18;
    cyc(3);
    chk("deep_keep", {pad_ctl[4].out, pad_ctl[2].ie}, 1);
    @(posedge clock);
    pad_in[2] <= 1'h1;
    wst(ST_HOLD);
    @(posedge clock);
    pad_in[2] <= 1'h0;
    mode_req <= REQ_RUN;
    cyc(4);
    chk("hold_keep", {power_state, pad_ctl[4].out}, 6);
    wr(OFS_CTRL, 32'h0);
    wst(ST_RUN);
    cyc(2);
    chk("run_out", pad_ctl[4].out, 1);
    $display("test hold done");
    @(posedge clock);
    mode_req <= REQ_DEEP;
    wst(ST_DEEP);
    @(posedge clock);
    mode_req <= REQ_RUN;
    wst(ST_STARTUP);
    cyc(1);
    chk("su_pads", {pad_ctl[0].oe_n, pad_ctl[0].out, pad_ctl[6].oe_n,
      pad_ctl[6].ie}, 6);
    wst(ST_RUN);
    $display("test startup done");
    @(posedge clock);
    mode_req <= REQ_LIGHT;
    wst(ST_LIGHT);
    @(posedge clock);
    srst <= 1'h1;
    mode_req <= REQ_RUN;
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    #1;
    chk("rst_mid", {power_state, pad_ctl[0].oe_n, pad_ctl[1].pu,
      pad_ctl[6].oe_n}, 3);
    rd(OFS_STATUS);
    chk("rst_stat", rv, 32'h0);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule // sphold_top_tb
`default_nettype wire
